// File: shared/nibble_port_pkg.sv
// constants for the paired 4-bit bidirectional port block
package nibble_port_pkg;
    // bus geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          NIB_W           = 4;

    // register indices as printed; byte address is four times the index
    localparam logic [9:0]  P0_DATA_IDX     = 10'h2ed;
    localparam logic [9:0]  P0_DIR_IDX      = 10'h2ee;
    localparam logic [9:0]  P1_DATA_IDX     = 10'h2fd;
    localparam logic [9:0]  P1_DIR_IDX      = 10'h2fe;
    localparam logic [11:0] P0_DATA_ADDR    = {P0_DATA_IDX, 2'b00};
    localparam logic [11:0] P0_DIR_ADDR     = {P0_DIR_IDX, 2'b00};
    localparam logic [11:0] P1_DATA_ADDR    = {P1_DATA_IDX, 2'b00};
    localparam logic [11:0] P1_DIR_ADDR     = {P1_DIR_IDX, 2'b00};

    // field positions and reset values
    localparam int          DIR_BIT         = 0;
    localparam logic        DIR_RESET       = 1'b0;
    localparam logic [3:0]  LATCH_RESET     = 4'h0;

    // read-time pull-down: 1.5 system clock cycles, held as half cycles
    localparam int          PULLDOWN_HALF   = 3;
    localparam int          PD_CYCLES       = (PULLDOWN_HALF + 1) / 2;
    // pins settle within 0.5 cycle, then the three-flop sampler must fill
    localparam int          SETTLE_HALF     = 1;
    localparam int          SYNC_STAGES     = 3;
    localparam int          SETTLE_CYCLES   = (SETTLE_HALF / 2) + SYNC_STAGES;
    localparam logic [2:0]  PD_LAST         = 3'(PD_CYCLES - 1);
    localparam logic [2:0]  SETTLE_LAST     = 3'(SETTLE_CYCLES - 1);

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

    typedef enum logic [1:0] {RD_IDLE, RD_PULL, RD_SETTLE, RD_RESP} rd_state_e;
endpackage : nibble_port_pkg

// File: src/pin_sampler.sv
// three-flop pin sampler; a bit changes once stages two and three agree
module pin_sampler
    import nibble_port_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    // pins and filtered level
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // s1 feeds only s2; the agreement test looks at stages two and three
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            level_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sampler

// File: src/nibble_port_pair.sv
// two 4-bit bidirectional ports with AXI4-Lite register access
// Notes on behaviour
// RULE1 - in output mode each pin drives its latch bit, one high, zero low
// RULE2 - latch writes are taken in input mode and appear once output is selected
// RULE3 - data reads return sampled pin levels, never the latch
// RULE4 - reading a data register turns on that port's pull-down
// RULE5 - the read pull-down lasts one and a half system cycles; the logic holds it for two full cycles
// RULE6 - one direction bit per group, one is output, zero input, readable
// RULE7 - reset clears both direction bits so every pin starts as input
// RULE8 - group zero data at the first address, group one at the second
// RULE9 - direction bits are bit zero of the two control locations
// RULE10 - latch contents after reset are not meaningful to the logic
// RULE11 - software on the fast oscillator rereads inputs for about 500 us
// RULE12 - slow pins need an external pull-down or repeated reads
// RULE13 - a direction change reaches the drivers the cycle after the write
//
// The AXI4-Lite slave port was chosen for this implementation.
module nibble_port_pair
    import nibble_port_pkg::*;
(
    // clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // AXI4-Lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    // AXI4-Lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // port group 0 pins
    input  wire logic [NIB_W-1:0]  port_group0_pins_in,
    output logic      [NIB_W-1:0]  port_group0_pins_out,
    output logic      [NIB_W-1:0]  port_group0_pins_oe,
    output logic                   port_group0_pulldown,
    // port group 1 pins
    input  wire logic [NIB_W-1:0]  port_group1_pins_in,
    output logic      [NIB_W-1:0]  port_group1_pins_out,
    output logic      [NIB_W-1:0]  port_group1_pins_oe,
    output logic                   port_group1_pulldown
);
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              wlane0_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic [ADDR_W-1:0] araddr_q;
    rd_state_e         rd_state_q;
    logic [2:0]        rd_cnt_q;
    logic [NIB_W-1:0]  latch0_q;
    logic [NIB_W-1:0]  latch1_q;
    logic [NIB_W-1:0]  oe0_q;
    logic [NIB_W-1:0]  oe1_q;
    logic              pd0_q;
    logic              pd1_q;
    logic [NIB_W-1:0]  level0;
    logic [NIB_W-1:0]  level1;
    logic              do_write;
    logic              ar_take;
    logic              ar_is_data;

    // unused protection bits: every access is treated alike
    logic              prot_unused;
    assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

    pin_sampler #(.W(NIB_W)) u_sample0 (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .pin_in   (port_group0_pins_in),
        .level_q  (level0)
    );

    pin_sampler #(.W(NIB_W)) u_sample1 (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .pin_in   (port_group1_pins_in),
        .level_q  (level1)
    );

    // write fires once both address and data are held and no answer is pending
    assign do_write   = !awready_q && !wready_q && !bvalid_q;
    assign ar_take    = s_axi_arvalid && arready_q;
    assign ar_is_data = (s_axi_araddr == P0_DATA_ADDR) || (s_axi_araddr == P1_DATA_ADDR);

    // write channels: address and data taken in either order
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= RDATA_ZERO;
            wlane0_q  <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wlane0_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q == P0_DATA_ADDR || awaddr_q == P0_DIR_ADDR ||
                             awaddr_q == P1_DATA_ADDR || awaddr_q == P1_DIR_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // data latches; a write stores regardless of direction
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            latch0_q <= LATCH_RESET; // RULE10
            latch1_q <= LATCH_RESET;
        end else if (ce && do_write && wlane0_q) begin
            if (awaddr_q == P0_DATA_ADDR) begin
                latch0_q <= wdata_q[NIB_W-1:0]; // RULE2 RULE8
            end
            if (awaddr_q == P1_DATA_ADDR) begin
                latch1_q <= wdata_q[NIB_W-1:0]; // RULE2 RULE8
            end
        end
    end

    // direction per group, fanned out to the four enables of the group
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            oe0_q <= {NIB_W{DIR_RESET}}; // RULE7
            oe1_q <= {NIB_W{DIR_RESET}}; // RULE7
        end else if (ce && do_write && wlane0_q) begin
            if (awaddr_q == P0_DIR_ADDR) begin
                oe0_q <= {NIB_W{wdata_q[DIR_BIT]}}; // RULE6 RULE9 RULE13
            end
            if (awaddr_q == P1_DIR_ADDR) begin
                oe1_q <= {NIB_W{wdata_q[DIR_BIT]}}; // RULE6 RULE9 RULE13
            end
        end
    end

    // read sequence: data reads pull down, wait for the sampler, then answer; other reads answer at once
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_state_q <= RD_IDLE;
            rd_cnt_q   <= '0;
            arready_q  <= 1'b1;
            araddr_q   <= '0;
            pd0_q      <= 1'b0;
            pd1_q      <= 1'b0;
        end else if (ce) begin
            unique case (rd_state_q)
                RD_IDLE: begin
                    if (ar_take) begin
                        arready_q <= 1'b0;
                        araddr_q  <= s_axi_araddr;
                        rd_cnt_q  <= '0;
                        pd0_q     <= (s_axi_araddr == P0_DATA_ADDR); // RULE4
                        pd1_q     <= (s_axi_araddr == P1_DATA_ADDR); // RULE4
                        rd_state_q <= ar_is_data ? RD_PULL : RD_RESP;
                    end
                end
                RD_PULL: begin
                    rd_cnt_q <= rd_cnt_q + 3'd1;
                    if (rd_cnt_q == PD_LAST) begin
                        pd0_q      <= 1'b0; // RULE5
                        pd1_q      <= 1'b0;
                        rd_cnt_q   <= '0;
                        rd_state_q <= RD_SETTLE;
                    end
                end
                RD_SETTLE: begin
                    rd_cnt_q <= rd_cnt_q + 3'd1;
                    if (rd_cnt_q == SETTLE_LAST) begin
                        rd_state_q <= RD_RESP;
                    end
                end
                RD_RESP: begin
                    if (rvalid_q && s_axi_rready) begin
                        arready_q  <= 1'b1;
                        rd_state_q <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // read answer; data registers show the pin levels, not the latch
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= RDATA_ZERO;
            rresp_q  <= RESP_OKAY;
        end else if (ce) begin
            if (rd_state_q == RD_IDLE && ar_take && !ar_is_data) begin
                rvalid_q <= 1'b1;
                rdata_q  <= RDATA_ZERO;
                rresp_q  <= RESP_OKAY;
                if (s_axi_araddr == P0_DIR_ADDR) begin
                    rdata_q[DIR_BIT] <= oe0_q[0]; // RULE6 RULE9
                end else if (s_axi_araddr == P1_DIR_ADDR) begin
                    rdata_q[DIR_BIT] <= oe1_q[0]; // RULE6 RULE9
                end else begin
                    rresp_q <= RESP_SLVERR;
                end
            end else if (rd_state_q == RD_SETTLE && rd_cnt_q == SETTLE_LAST) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OKAY;
                rdata_q  <= {28'h000_0000, (araddr_q == P0_DATA_ADDR) ? level0 : level1}; // RULE3
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // pins drive straight from the latch and direction flops
    assign port_group0_pins_out = latch0_q; // RULE1
    assign port_group1_pins_out = latch1_q; // RULE1
    assign port_group0_pins_oe  = oe0_q;
    assign port_group1_pins_oe  = oe1_q;
    assign port_group0_pulldown = pd0_q;
    assign port_group1_pulldown = pd1_q;
    assign s_axi_awready        = awready_q;
    assign s_axi_wready         = wready_q;
    assign s_axi_bvalid         = bvalid_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = arready_q;
    assign s_axi_rvalid         = rvalid_q;
    assign s_axi_rdata          = rdata_q;
    assign s_axi_rresp          = rresp_q;

    // helper: no direction write seen since reset
    logic dir_touched_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dir_touched_q <= 1'b0;
        end else if (ce && do_write && (awaddr_q == P0_DIR_ADDR || awaddr_q == P1_DIR_ADDR)) begin
            dir_touched_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn || !ce);

    AST_DATA_WRITE_TO_PIN: assert property ( // RULE1 RULE2
        (do_write && wlane0_q && awaddr_q == P0_DATA_ADDR) |=> port_group0_pins_out == $past(wdata_q[3:0])
    ) else $error("group 0 pins do not carry written data");

    AST_READ_RETURNS_LEVEL: assert property ( // RULE3
        (rd_state_q == RD_SETTLE && rd_cnt_q == SETTLE_LAST && araddr_q == P1_DATA_ADDR)
        |=> s_axi_rvalid && s_axi_rdata == {28'h000_0000, $past(level1)}
    ) else $error("group 1 read does not show sampled pin level");

    AST_READ_PULLS_DOWN: assert property ( // RULE4
        (rd_state_q == RD_IDLE && ar_take && s_axi_araddr == P0_DATA_ADDR)
        |=> port_group0_pulldown && !port_group1_pulldown
    ) else $error("group 0 read without pull-down");

    AST_PULLDOWN_LENGTH: assert property ( // RULE5
        $rose(port_group1_pulldown) |-> port_group1_pulldown[*2] ##1 !port_group1_pulldown
    ) else $error("pull-down not held exactly two cycles");

    AST_DIR_TAKES_EFFECT: assert property ( // RULE6 RULE13
        (do_write && wlane0_q && awaddr_q == P1_DIR_ADDR)
        |=> port_group1_pins_oe == {4{$past(wdata_q[0])}}
    ) else $error("group 1 direction not applied next cycle");

    AST_INPUT_AFTER_RESET: assert property ( // RULE7
        !dir_touched_q |-> (port_group0_pins_oe == 4'h0 && port_group1_pins_oe == 4'h0)
    ) else $error("pin driven before any direction write");

    AST_GROUP_ISOLATION: assert property ( // RULE8
        (do_write && awaddr_q == P1_DATA_ADDR) |=> $stable(port_group0_pins_out)
    ) else $error("group 1 write disturbed group 0 latch");

    AST_DIR_READBACK: assert property ( // RULE9
        (rd_state_q == RD_IDLE && ar_take && s_axi_araddr == P0_DIR_ADDR)
        |=> s_axi_rvalid && s_axi_rdata == {31'h0000_0000, $past(oe0_q[0])}
    ) else $error("direction read-back wrong");

    AST_WRITE_ANSWER: assert property ( // RULE2
        do_write |=> s_axi_bvalid
    ) else $error("write not answered");

    COV_OUTPUT_MODE: cover property (port_group0_pins_oe == 4'hf ##1 port_group0_pins_out != 4'h0);
    COV_DATA_READ:   cover property (rd_state_q == RD_SETTLE ##[1:8] s_axi_rvalid && s_axi_rready);
    COV_BAD_ADDR:    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : nibble_port_pair

// File: testbench/pin_load_model.sv
// external circuitry on one 4-bit port: drivers, line charge and a heavy load
module pin_load_model (
    // from the port
    input  wire logic [3:0] pins_out,
    input  wire logic [3:0] pins_oe,
    input  wire logic       pull_on,
    // bench controls
    input  wire logic [3:0] ext_level,
    input  wire logic [3:0] ext_drive,
    input  wire logic       heavy,
    // to the port
    output logic      [3:0] pins_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // an undriven line keeps its charge; it starts charged high so a read must pull it down
    logic [3:0] line_q = 4'hf;

    always @* begin
        for (int i = 0; i < 4; i++) begin
            if (pins_oe[i]) begin
                // a low-impedance load wins over the port driver
                line_q[i] = heavy ? 1'b0 : pins_out[i];
            end else if (ext_drive[i]) begin
                line_q[i] = ext_level[i];
            end else if (pull_on) begin
                line_q[i] = 1'b0;
            end
        end
    end

    assign pins_in = line_q;
endmodule : pin_load_model

// File: testbench/nibble_port_pair_tb_top.sv
// self-checking bench for the paired nibble port block
module nibble_port_pair_tb_top
    import nibble_port_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0, resetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pd;
    logic [3:0]  pin_in [2], pin_out [2], pin_oe [2];
    logic [3:0]  ext_lvl [2] = '{4'h0, 4'h0};
    logic [3:0]  ext_drv [2] = '{4'h0, 4'h0};
    logic        heavy [2] = '{1'b0, 1'b0};
    logic [33:0] exp_r [$];
    logic [1:0]  exp_b [$];
    logic [31:0] d;
    int          error_cnt = 0, samples_checked = 0, cycles = 0, seed = 32'h5849;
    int          pd_len [2] = '{0, 0};
    int          pd_pulses [2] = '{0, 0};
    int          p0;

    always #25 core_clk = ~core_clk;

    nibble_port_pair nibble_port_pair_inst (
        .core_clk(core_clk), .resetn(resetn), .ce(1'b1),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'b000), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'b000),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .port_group0_pins_in(pin_in[0]), .port_group0_pins_out(pin_out[0]),
        .port_group0_pins_oe(pin_oe[0]), .port_group0_pulldown(pd[0]),
        .port_group1_pins_in(pin_in[1]), .port_group1_pins_out(pin_out[1]),
        .port_group1_pins_oe(pin_oe[1]), .port_group1_pulldown(pd[1])
    );

    for (genvar g = 0; g < 2; g++) begin : gen_load
        pin_load_model pin_load_model_inst (
            .pins_out(pin_out[g]), .pins_oe(pin_oe[g]), .pull_on(pd[g]), .ext_level(ext_lvl[g]),
            .ext_drive(ext_drv[g]), .heavy(heavy[g]), .pins_in(pin_in[g])
        );
    end

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // address and data offered together, each released at its own handshake
    task automatic axi_write(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] st, input logic [1:0] er);
        exp_b.push_back(er);
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= dt;
        s_axi_wstrb   <= st;
        s_axi_bready  <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        while (1'b1) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [33:0] ex);
        exp_r.push_back(ex);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        while (1'b1) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic chk_pins(input int g, input logic [3:0] o, input logic [3:0] e);
        check("pins_oe", 34'(e), 34'(pin_oe[g]));
        if (e !== 4'h0) check("pins_out", 34'(o), 34'(pin_out[g]));
    endtask : chk_pins

    // monitor: answers against the oldest note, pull-down pulse lengths
    always @(posedge core_clk) begin
        if (resetn && s_axi_bvalid && s_axi_bready && exp_b.size() > 0) begin
            check("bresp", 34'(exp_b.pop_front()), 34'(s_axi_bresp));
        end
        if (resetn && s_axi_rvalid && s_axi_rready && exp_r.size() > 0) begin
            check("rresp_rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        for (int g = 0; g < 2; g++) begin
            if (pd[g] === 1'b1) begin
                pd_len[g]++;
            end else if (pd_len[g] != 0) begin
                check("pulldown_cycles", 34'(2), 34'(pd_len[g]));
                pd_pulses[g]++;
                pd_len[g] = 0;
            end
        end
    end

    // watchdog sized well above the roughly 320 cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk_pins(0, 4'h0, 4'h0);
        chk_pins(1, 4'h0, 4'h0);
        axi_read(P0_DIR_ADDR, {RESP_OKAY, 32'h0000_0000});
        axi_read(P1_DIR_ADDR, {RESP_OKAY, 32'h0000_0000});
        $display("test reset done");
        ext_drv[0] <= 4'hf;
        ext_drv[1] <= 4'hf;
        ext_lvl[0] <= 4'h5;
        ext_lvl[1] <= 4'ha;
        axi_write(P0_DATA_ADDR, 32'hffff_fff3, 4'hf, RESP_OKAY);
        axi_write(P1_DATA_ADDR, 32'h0000_000c, 4'hf, RESP_OKAY);
        chk_pins(0, 4'h0, 4'h0);
        repeat (6) @(posedge core_clk);
        axi_read(P0_DATA_ADDR, {RESP_OKAY, 32'h0000_0005});
        axi_read(P1_DATA_ADDR, {RESP_OKAY, 32'h0000_000a});
        $display("test input mode done");
        ext_drv[0] <= 4'h0;
        ext_drv[1] <= 4'h0;
        axi_write(P0_DIR_ADDR, 32'hffff_fff1, 4'hf, RESP_OKAY);
        chk_pins(0, 4'h3, 4'hf);
        chk_pins(1, 4'h0, 4'h0);
        axi_write(P1_DIR_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
        chk_pins(1, 4'hc, 4'hf);
        axi_read(P0_DIR_ADDR, {RESP_OKAY, 32'h0000_0001});
        axi_write(P1_DATA_ADDR, 32'h0000_0003, 4'h0, RESP_OKAY);
        chk_pins(1, 4'hc, 4'hf);
        repeat (6) @(posedge core_clk);
        axi_read(P0_DATA_ADDR, {RESP_OKAY, 32'h0000_0003});
        heavy[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        axi_read(P0_DATA_ADDR, {RESP_OKAY, 32'h0000_0000});
        heavy[0] <= 1'b0;
        $display("test output mode done");
        axi_write(P0_DIR_ADDR, 32'h0000_0000, 4'hf, RESP_OKAY);
        chk_pins(0, 4'h0, 4'h0);
        // line left charged high and undriven: only the read pull-down brings it low
        ext_lvl[0] <= 4'hf;
        ext_drv[0] <= 4'hf;
        repeat (6) @(posedge core_clk);
        ext_drv[0] <= 4'h0;
        p0 = pd_pulses[0];
        axi_read(P0_DATA_ADDR, {RESP_OKAY, 32'h0000_0000});
        check("pulldown_pulses", 34'(p0 + 1), 34'(pd_pulses[0]));
        axi_write(12'h100, 32'h0000_0001, 4'hf, RESP_SLVERR);
        axi_read(12'h100, {RESP_SLVERR, 32'h0000_0000});
        axi_read(P1_DIR_ADDR, {RESP_OKAY, 32'h0000_0001});
        repeat (4) @(posedge core_clk);
        check("pulldown_pulses", 34'(p0 + 1), 34'(pd_pulses[0]));
        // software habit on a slow line: read the input several times in a row
        for (int i = 0; i < 3; i++) begin
            axi_read(P0_DATA_ADDR, {RESP_OKAY, 32'h0000_0000});
        end
        $display("test pull-down done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            axi_write(P1_DATA_ADDR, d, 4'hf, RESP_OKAY);
            chk_pins(1, d[3:0], 4'hf);
            ext_lvl[0] <= d[7:4];
            ext_drv[0] <= 4'hf;
            repeat (6) @(posedge core_clk);
            axi_read(P0_DATA_ADDR, {RESP_OKAY, 28'h000_0000, d[7:4]});
        end
        $display("test random done");
        repeat (10) @(posedge core_clk);
        check("pending_answers", 34'(0), 34'(exp_r.size() + exp_b.size()));
        stop_test();
    end
endmodule : nibble_port_pair_tb_top
